//--- dv/arf_filter_model.sv
// filter and sequencer stand-in, one result pulse per request
`timescale 1ns/1ps
`default_nettype none
module arf_filter_model (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        send_i,
  input  wire logic [23:0] data_i,
  input  wire logic [3:0]  chan_i,
  output logic             filt_valid_o,
  output logic [23:0]      filt_data_o,
  output logic [3:0]       scan_channel_o
);
  // data outside a pulse is scrambled so nothing leans on stale values
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      filt_valid_o   <= 1'b0;
      filt_data_o    <= 24'h0;
      scan_channel_o <= 4'h0;
    end else begin
      filt_valid_o   <= send_i;
      filt_data_o    <= send_i ? data_i : ~filt_data_o;
      scan_channel_o <= chan_i;
    end
  end
endmodule
`default_nettype wire

//--- dv/arf_result_formatter_assertions.sv
// concurrent checks on the result formatter ports
`timescale 1ns/1ps
`default_nettype none
module arf_result_formatter_assertions (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        filt_valid_i,
  input wire logic [31:0] result_o,
  input wire logic        result_wide_o,
  input wire logic        result_new_o
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_lat; result_new_o |-> $past(filt_valid_i, 3); endproperty
  a_lat: assert property (p_lat) else $error("result not three cycles after take");
  property p_gap; result_new_o |=> !result_new_o [*2]; endproperty
  a_gap: assert property (p_gap) else $error("result pulses too close");
  property p_whole; $changed(result_o) |-> result_new_o; endproperty
  a_whole: assert property (p_whole) else $error("result moved without update");
  property p_f00; result_new_o && !result_wide_o |-> result_o[31:16] == 16'h0000; endproperty
  a_f00: assert property (p_f00) else $error("narrow result has upper bits");
  property p_sign;
    result_wide_o && result_o[15:0] != 16'h0 |-> result_o[27:17] == {11{result_o[16]}};
  endproperty
  a_sign: assert property (p_sign) else $error("sign fill wrong");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  c_wide: cover property (result_new_o && result_wide_o);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_wr: cover property (s_axi_bvalid);
endmodule
`default_nettype wire

//--- dv/arf_result_formatter_tb.sv
// self-checking bench for the result formatter
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module arf_result_formatter_tb;
  logic        clock_i = 1'b0, rst_i = 1'b1, send = 1'b0, fv, wide, newr;
  logic [23:0] fdata = 24'h0, fd;
  logic [3:0]  chan = 4'h0, sc;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, result, seed = 32'hf526;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0, num_checks = 0;
  always #4 clock_i = ~clock_i;
  arf_filter_model fm_u (.clock_i(clock_i), .rst_i(rst_i), .send_i(send), .data_i(fdata),
    .chan_i(chan), .filt_valid_o(fv), .filt_data_o(fd), .scan_channel_o(sc));
  arf_result_formatter dut_u (.clock_i(clock_i), .rst_i(rst_i), .filt_valid_i(fv),
    .filt_data_i(fd), .scan_channel_i(sc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .result_o(result), .result_wide_o(wide), .result_new_o(newr));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] exp_word(logic [23:0] f, logic [7:0] g, logic [1:0] fm,
      logic s, logic [3:0] c);
    int v;
    int r;
    v = $signed(f);
    r = (((v * int'(g)) >>> 2) + 128) >>> 8;
    if (fm[1]) r = (r > 65535) ? 65535 : (r < -65536) ? -65536 : r;
    else r = (r > 32767) ? 32767 : (r < -32768) ? -32768 : r;
    case (fm)
      2'b00: return {16'h0, r[15:0]};
      2'b01: return {r[15:0], 16'h0};
      2'b10: return {{15{r[16]}}, r[16:0]};
      default: return {s ? c : 4'h0, {11{r[16]}}, r[16:0]};
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clock_i);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      r = bresp;
      @(posedge clock_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
    @(posedge clock_i);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clock_i);
      ha = arvalid & arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock_i);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
    @(posedge clock_i);
  endtask
  // one conversion; dbl sends a second pulse while busy, which must be dropped
  task automatic conv(input logic [23:0] f, input logic [7:0] g, input logic [1:0] fm,
      input logic s, input logic [3:0] c, input logic dbl);
    logic [31:0] e, d;
    logic [1:0] rr;
    int n;
    axw(`ARF_OFS_CONTROL, {20'h0, g, 1'b0, s, fm}, `ARF_RESP_OKAY);
    e = exp_word(f, g, fm, s, c);
    chan <= c;
    fdata <= f;
    send <= 1'b1;
    @(posedge clock_i);
    fdata <= ~f;
    send <= dbl;
    @(posedge clock_i);
    send <= 1'b0;
    n = 0;
    do begin
      @(negedge clock_i);
      n++;
    end while (newr !== 1'b1 && n < 20);
    chk(result, e);
    chk({31'h0, wide}, {31'h0, fm != 2'b00});
    @(posedge clock_i);
    axr(`ARF_OFS_RESULT, d, rr);
    chk(d, e);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    logic [31:0] d, f;
    logic [1:0] rr;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    axr(`ARF_OFS_RESULT, d, rr);
    chk(d, 32'h0);
    axr(`ARF_OFS_CONTROL, d, rr);
    chk(d, 32'h0000_0040);
    axr(8'h0c, d, rr);
    chk({30'h0, rr}, {30'h0, `ARF_RESP_SLVERR});
    axw(`ARF_OFS_RESULT, 32'h1234, `ARF_RESP_SLVERR);
    conv(24'h7fffff, 8'h04, 2'b00, 1'b0, 4'h0, 1'b0);
    conv(24'h800000, 8'h04, 2'b01, 1'b0, 4'h0, 1'b0);
    conv(24'h7fffff, 8'h08, 2'b10, 1'b1, 4'h5, 1'b0);
    conv(24'h800000, 8'h08, 2'b11, 1'b1, 4'ha, 1'b1);
    conv(24'h7fff7f, 8'h04, 2'b11, 1'b0, 4'hc, 1'b0);
    for (int i = 0; i < 40; i++) begin
      f = rnd();
      if (f[7:0] == 8'h80) f[0] = 1'b1;
      conv(f[23:0], 8'h04, i[1:0], f[24], f[31:28], i % 7 == 3);
    end
    conclude();
  end
endmodule
bind arf_result_formatter arf_result_formatter_assertions chk_u (.clock_i(clock_i),
  .rst_i(rst_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .filt_valid_i(filt_valid_i),
  .result_o(result_o), .result_wide_o(result_wide_o), .result_new_o(result_new_o));
`default_nettype wire

//--- rtl/arf_consts.svh
// offsets, field positions, reset values and code limits of the result formatter
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH
`define ARF_OFS_RESULT      8'h00
`define ARF_OFS_CONTROL     8'h04
`define ARF_OFS_STATUS      8'h08
`define ARF_CTL_FMT_LSB     0
`define ARF_CTL_SCAN_BIT    2
`define ARF_CTL_GAIN_LSB    4
`define ARF_CTL_RESET       32'h0000_0040
`define ARF_MAX16           17'h0_7fff
`define ARF_MIN16           17'h1_8000
`define ARF_MAX17           17'h0_ffff
`define ARF_MIN17           17'h1_0000
`define ARF_FULL_SCALE      32768
`define ARF_RESP_OKAY       2'b00
`define ARF_RESP_SLVERR     2'b10
`endif

//--- rtl/arf_pkg.sv
// types shared by the result formatter files
package arf_pkg;
  typedef enum logic [1:0] {
    ARF_FMT_16      = 2'b00,
    ARF_FMT_32_LEFT = 2'b01,
    ARF_FMT_32_SGN  = 2'b10,
    ARF_FMT_32_TAG  = 2'b11
  } arf_fmt_t;
  typedef enum logic [1:0] {
    ARF_ST_IDLE,
    ARF_ST_SCALE,
    ARF_ST_WRITE
  } arf_state_t;
endpackage

//--- rtl/arf_result_formatter.sv
// result formatter top: axi4-lite slave, format layouts and result register
//
// Overview of operation
// - result register at offset 0, 16-bit default
// - round wide filter result to nearest lsb
// - code equals vin/vref times 32768 times gain
// - two-bit format picks one of four layouts
// - upper format bit 0: 16-bit signed, msb first
// - 16-bit clamps at 7fff and 8000
// - format 00: only the 16-bit value
// - format 01: 32 bits, left justified, zero low half
// - upper format bit 1: 17-bit code, 32 bits
// - 17-bit clamps at 0ffff and 10000
// - 17-bit code is clipped on its own, one bit wider than the 16-bit code
// - format 10: right justified, sign-filled upper 15 bits
// - format 11: channel tag in top nibble
// - channel tag reads zero when not scanning
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module arf_result_formatter #(
  parameter int FILT_W = 24,
  parameter int FRAC_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  // filter and sequencer side
  input  wire logic              filt_valid_i,
  input  wire logic [FILT_W-1:0] filt_data_i,
  input  wire logic [3:0]        scan_channel_i,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // result handed to the serial side
  output logic [31:0]            result_o,
  output logic                   result_wide_o,
  output logic                   result_new_o
);

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  logic [31:0] control;
  logic [31:0] status;

  wire arf_pkg::arf_fmt_t fmt_w;
  wire logic              scan_w;
  wire logic [7:0]        gain_w;

  assign fmt_w  = arf_pkg::arf_fmt_t'(control[`ARF_CTL_FMT_LSB +: 2]);
  assign scan_w = control[`ARF_CTL_SCAN_BIT];
  assign gain_w = control[`ARF_CTL_GAIN_LSB +: 8];

  // ------------------------------------------------------------
  // conversion path
  // ------------------------------------------------------------
  arf_pkg::arf_state_t state;
  arf_pkg::arf_state_t next_state;
  logic [FILT_W-1:0]   filt_hold;
  logic [3:0]          tag_hold;
  arf_pkg::arf_fmt_t   fmt_hold;
  wire logic [16:0]    code_w;
  wire logic           done_w;
  wire logic           start_w;

  assign start_w = (state == arf_pkg::ARF_ST_IDLE) && filt_valid_i;

  arf_scale_round #(
    .FILT_W (FILT_W),
    .FRAC_W (FRAC_W)
  ) u_scale (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (state == arf_pkg::ARF_ST_SCALE),
    .filt_i  (filt_hold),
    .gain_i  (gain_w),
    .wide_i  (fmt_hold[1]),
    .code_o  (code_w),
    .done_o  (done_w)
  );

  always_comb begin
    case (state)
      arf_pkg::ARF_ST_IDLE:  next_state = filt_valid_i ? arf_pkg::ARF_ST_SCALE
                                                       : arf_pkg::ARF_ST_IDLE;
      arf_pkg::ARF_ST_SCALE: next_state = arf_pkg::ARF_ST_WRITE;
      arf_pkg::ARF_ST_WRITE: next_state = done_w ? arf_pkg::ARF_ST_IDLE
                                                 : arf_pkg::ARF_ST_WRITE;
      default:               next_state = arf_pkg::ARF_ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // layout selection
  // ------------------------------------------------------------
  function automatic logic [31:0] arf_layout(input arf_pkg::arf_fmt_t f,
                                             input logic [16:0] c,
                                             input logic [3:0] tag);
    case (f)
      arf_pkg::ARF_FMT_16:      arf_layout = {16'h0000, c[15:0]};
      arf_pkg::ARF_FMT_32_LEFT: arf_layout = {c[15:0], 16'h0000};
      arf_pkg::ARF_FMT_32_SGN:  arf_layout = {{15{c[16]}}, c};
      arf_pkg::ARF_FMT_32_TAG:  arf_layout = {tag, {11{c[16]}}, c};
      default:                  arf_layout = 32'h0000_0000;
    endcase
  endfunction

  wire logic [31:0] layout_w;
  assign layout_w = arf_layout(fmt_hold, code_w, tag_hold);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state         <= arf_pkg::ARF_ST_IDLE;
      filt_hold     <= '0;
      tag_hold      <= 4'h0;
      fmt_hold      <= arf_pkg::ARF_FMT_16;
      result_o      <= 32'h0000_0000;
      result_wide_o <= 1'b0;
      result_new_o  <= 1'b0;
    end else begin
      state        <= next_state;
      result_new_o <= 1'b0;
      if (start_w) begin
        filt_hold <= filt_data_i;
        fmt_hold  <= fmt_w;
        tag_hold  <= scan_w ? scan_channel_i : 4'h0;
      end
      if (state == arf_pkg::ARF_ST_WRITE && done_w) begin
        result_o      <= layout_w;
        result_wide_o <= (fmt_hold != arf_pkg::ARF_FMT_16);
        result_new_o  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------
  logic       aw_held;
  logic [7:0] aw_addr;
  logic       w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic do_write_w;
  wire logic wr_ctl_w;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write_w    = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctl_w      = (aw_addr[7:2] == `ARF_OFS_CONTROL >> 2);

  function automatic logic [31:0] arf_merge(input logic [31:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    return old;
  endfunction

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ARF_RESP_OKAY;
      control      <= `ARF_CTL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write_w) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ctl_w ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
        if (wr_ctl_w) begin
          control <= arf_merge(control, w_data, w_strb) & 32'h0000_0ff7;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------
  wire logic [5:0]  rd_idx_w;
  wire logic        rd_hit_w;
  wire logic [31:0] rd_mux_w;

  assign status        = {29'h0, result_wide_o, fmt_hold};
  assign rd_idx_w      = s_axi_araddr[7:2];
  assign rd_hit_w      = (rd_idx_w == `ARF_OFS_RESULT >> 2) ||
                         (rd_idx_w == `ARF_OFS_CONTROL >> 2) ||
                         (rd_idx_w == `ARF_OFS_STATUS >> 2);
  assign rd_mux_w      = (rd_idx_w == `ARF_OFS_RESULT >> 2)  ? result_o :
                         (rd_idx_w == `ARF_OFS_CONTROL >> 2) ? control  :
                         (rd_idx_w == `ARF_OFS_STATUS >> 2)  ? status   : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ARF_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux_w;
        s_axi_rresp  <= rd_hit_w ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/arf_scale_round.sv
// rounding, gain scaling and clipping of the wide filter result
`timescale 1ns/1ps
`default_nettype none
`include "arf_consts.svh"
module arf_scale_round #(
  parameter int FILT_W = 24,
  parameter int FRAC_W = 8
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              start_i,
  input  wire logic [FILT_W-1:0] filt_i,
  input  wire logic [7:0]        gain_i,
  input  wire logic              wide_i,
  output logic [16:0]            code_o,
  output logic                   done_o
);
  localparam int PW = FILT_W + 10;

  // ------------------------------------------------------------
  // arithmetic
  // ------------------------------------------------------------
  // round to nearest by adding half an lsb before dropping fraction
  function automatic logic signed [PW-1:0] round_drop(input logic signed [PW-1:0] v);
    logic signed [PW-1:0] half;
    half = PW'(1) <<< (FRAC_W - 1);
    return (v + half) >>> FRAC_W;
  endfunction

  wire logic signed [PW-1:0] prod_w;
  wire logic signed [PW-1:0] rnd_w;
  wire logic                 over_w;
  wire logic                 under_w;
  wire logic [16:0]          clip_w;

  // gain has 2 fractional bits, so x4 then shift back by 2 before the rounding
  assign prod_w  = PW'($signed(filt_i)) * $signed({1'b0, gain_i});
  assign rnd_w   = round_drop(prod_w >>> 2);
  assign over_w  = wide_i ? (rnd_w > PW'(65535)) : (rnd_w > PW'(32767));
  assign under_w = wide_i ? (rnd_w < -PW'(65536)) : (rnd_w < -PW'(32768));
  assign clip_w  = over_w  ? (wide_i ? `ARF_MAX17 : `ARF_MAX16) :
                   under_w ? (wide_i ? `ARF_MIN17 : `ARF_MIN16) :
                   rnd_w[16:0];

  // ------------------------------------------------------------
  // output register
  // ------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      code_o <= 17'h0_0000;
      done_o <= 1'b0;
    end else begin
      done_o <= start_i;
      if (start_i) begin
        code_o <= clip_w;
      end
    end
  end
endmodule
`default_nettype wire
